// ### shared/uart_lsl_consts.vh
// Purpose: constants of the serial port line status logic
// Assumes: 4-bit register index, 8-bit register data
// Notes:   offsets are byte indices on the plain register port
`ifndef UART_LSL_CONSTS_VH
`define UART_LSL_CONSTS_VH

// register offsets
`define OFS_DATA      4'h0
`define OFS_IRQ_EN    4'h1
`define OFS_FIFO_CTRL 4'h2
`define OFS_LINE_CTRL 4'h3
`define OFS_MODEM     4'h4
`define OFS_LSTAT     4'h5
`define OFS_EVT_STAT  4'h8
`define OFS_EVT_MASK  4'h9

// line status field positions
`define LS_DREADY     0
`define LS_OVERRUN    1
`define LS_PARITY     2
`define LS_FRAME      3
`define LS_BREAK      4
`define LS_HOLD_EMPTY 5
`define LS_TX_EMPTY   6
`define LS_FIFO_ERR   7

// control field positions
`define MC_TERM_READY 0
`define FC_FIFO_MODE  0
`define LC_PAR_EN     3
`define LC_PAR_EVEN   4
`define IE_RX_DATA    0
`define IE_HOLD_EMPTY 1
`define IE_LINE_STAT  2

// event status bits
`define EV_RX_CHAR    0
`define EV_LINE_ERR   1
`define EV_HOLD_EMPTY 2

// reset values
`define RST_BYTE      8'h00
`define RST_EVT       3'h0

// queue depth and timing
`define Q_DEPTH       5'h10
`define Q_ONE         5'h01
`define BIT_CYCLES    16'h0010
`define HALF_CYCLES   16'h0008

`endif

// ### core/uart_line_status_logic.v
// Purpose: line status, transmit/receive queues and terminal-ready output
// Assumes: 8 data bits, 1 stop bit, optional parity, fixed bit time
// Notes:   queue depth is 16 in fifo mode and 1 in 450 mode
`timescale 1ns/1ps
`include "uart_lsl_consts.vh"

module uart_line_status_logic (
  // clock and reset
  input  wire       CLK_SYS,
  input  wire       RESETN,
  // register port
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // serial line and modem output
  input  wire       RXD,
  output reg        TXD,
  output reg        TERMINAL_READY_OUT_N,
  // interrupts
  output wire       SERIAL_IRQ,
  output wire       IRQ
);

  localparam [3:0] RX_IDLE  = 4'b0001;
  localparam [3:0] RX_START = 4'b0010;
  localparam [3:0] RX_DATA  = 4'b0100;
  localparam [3:0] RX_STOP  = 4'b1000;

  // control registers
  reg  [7:0]  irq_en_r;
  reg         fifo_mode_r;
  reg  [7:0]  line_ctrl_r;
  reg  [7:0]  modem_control_r;
  reg  [2:0]  evt_stat_r;
  reg  [2:0]  evt_mask_r;

  // transmit queue and shifter
  reg  [7:0]  tx_queue_mem [0:15];
  reg  [3:0]  txq_wp_r;
  reg  [3:0]  txq_rp_r;
  reg  [4:0]  txq_cnt_r;
  reg         tx_busy_r;
  reg  [10:0] tx_shift_reg;
  reg  [3:0]  tx_bits_r;
  reg  [15:0] tx_cnt_r;
  reg         hold_empty_d_r;

  // receiver
  reg         rx_s1_r;
  reg         rx_s2_r;
  reg         rx_s3_r;
  reg         rx_lvl_r;
  reg  [3:0]  rx_st_r;
  reg  [15:0] rx_cnt_r;
  reg  [3:0]  rx_idx_r;
  reg  [8:0]  rx_sh_r;

  // receive queue: {break, frame, parity, data}
  reg  [10:0] rxq_mem [0:15];
  reg  [3:0]  rxq_wp_r;
  reg  [3:0]  rxq_rp_r;
  reg  [4:0]  rxq_cnt_r;
  reg  [4:0]  rx_err_cnt_r;
  reg  [4:0]  rx_err_cnt_nxt;
  reg         head_shown_r;

  // line status flags
  reg         overrun_r;
  reg         parity_err_r;
  reg         frame_err_r;
  reg         break_r;
  reg         fifo_err_r;
  reg         fifo_err_nxt;

  // register decode
  wire wr_data  = WR & (ADDR == `OFS_DATA);
  wire wr_ien   = WR & (ADDR == `OFS_IRQ_EN);
  wire wr_fctl  = WR & (ADDR == `OFS_FIFO_CTRL);
  wire wr_lctl  = WR & (ADDR == `OFS_LINE_CTRL);
  wire wr_mctl  = WR & (ADDR == `OFS_MODEM);
  wire wr_estat = WR & (ADDR == `OFS_EVT_STAT);
  wire wr_emask = WR & (ADDR == `OFS_EVT_MASK);
  wire rd_data  = RD & (ADDR == `OFS_DATA);
  wire rd_lstat = RD & (ADDR == `OFS_LSTAT);

  // a mode change empties both queues
  wire q_flush = wr_fctl & (WDATA[`FC_FIFO_MODE] != fifo_mode_r);
  wire [4:0] q_cap = fifo_mode_r ? `Q_DEPTH : `Q_ONE;
  wire par_en   = line_ctrl_r[`LC_PAR_EN];
  wire par_even = line_ctrl_r[`LC_PAR_EVEN];

  // transmit side
  wire txq_push = wr_data & (txq_cnt_r < q_cap) & ~q_flush;
  wire txq_pop  = ~tx_busy_r & (txq_cnt_r != 5'h00) & ~q_flush;
  wire [7:0] tx_byte = tx_queue_mem[txq_rp_r];
  wire tx_par = par_even ? (^tx_byte) : ~(^tx_byte);
  wire holding_empty_bit = (txq_cnt_r == 5'h00);
  wire tx_empty = holding_empty_bit & ~tx_busy_r;

  // receive side
  wire rx_done = (rx_st_r == RX_STOP) & (rx_cnt_r == 16'h0000);
  wire rx_fe   = rx_done & ~rx_lvl_r;
  wire rx_pe   = par_en & (rx_sh_r[8] !=
                 (par_even ? (^rx_sh_r[7:0]) : ~(^rx_sh_r[7:0])));
  wire rx_bi   = rx_fe & (rx_sh_r == 9'h000);
  wire [10:0] rx_entry = {rx_bi, rx_fe, rx_pe, rx_sh_r[7:0]};
  wire rx_entry_err = rx_bi | rx_fe | rx_pe;
  wire rxq_pop  = rd_data & (rxq_cnt_r != 5'h00) & ~q_flush;
  wire rxq_room = (rxq_cnt_r < q_cap) | rxq_pop;
  wire rxq_push = rx_done & rxq_room & ~q_flush;
  // 450 mode replaces the unread byte, fifo mode drops the new one
  wire rx_overrun = rx_done & ~rxq_room & ~q_flush;
  wire rxq_ovw  = rx_overrun & ~fifo_mode_r;
  wire [10:0] rx_head = rxq_mem[rxq_rp_r];
  wire head_err = rx_head[10] | rx_head[9] | rx_head[8];
  wire show_evt = (rxq_cnt_r != 5'h00) & ~head_shown_r;
  wire data_ready = (rxq_cnt_r != 5'h00);

  wire [7:0] line_status_reg = {
    fifo_err_r & fifo_mode_r,
    tx_empty, holding_empty_bit, break_r, frame_err_r,
    parity_err_r, overrun_r, data_ready};

  // event sources
  wire [2:0] evt_set = {holding_empty_bit & ~hold_empty_d_r,
                        rx_overrun | (show_evt & head_err),
                        rxq_push};
  wire [2:0] evt_clr = wr_estat ? WDATA[2:0] : 3'h0;

  assign IRQ = |(evt_stat_r & evt_mask_r);
  assign SERIAL_IRQ =
    (irq_en_r[`IE_HOLD_EMPTY] & holding_empty_bit) |
    (irq_en_r[`IE_RX_DATA] & data_ready) |
    (irq_en_r[`IE_LINE_STAT] &
     (overrun_r | parity_err_r | frame_err_r | break_r));

  // control registers, read port, modem output
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      irq_en_r             <= `RST_BYTE;
      fifo_mode_r          <= 1'b0;
      line_ctrl_r          <= `RST_BYTE;
      modem_control_r      <= `RST_BYTE;
      evt_stat_r           <= `RST_EVT;
      evt_mask_r           <= `RST_EVT;
      TERMINAL_READY_OUT_N <= 1'b1;
      RDATA                <= `RST_BYTE;
      hold_empty_d_r       <= 1'b1;
    end else begin
      hold_empty_d_r <= holding_empty_bit;
      if (wr_ien)
        irq_en_r <= {5'h00, WDATA[2:0]};
      if (wr_fctl)
        fifo_mode_r <= WDATA[`FC_FIFO_MODE];
      if (wr_lctl)
        line_ctrl_r <= WDATA;
      if (wr_mctl) begin
        modem_control_r      <= {3'h0, WDATA[4:0]};
        TERMINAL_READY_OUT_N <= ~WDATA[`MC_TERM_READY];
      end
      if (wr_emask)
        evt_mask_r <= WDATA[2:0];
      evt_stat_r <= evt_set | (evt_stat_r & ~evt_clr);
      if (RD) begin
        case (ADDR)
          `OFS_DATA:      RDATA <= data_ready ? rx_head[7:0] : 8'h00;
          `OFS_IRQ_EN:    RDATA <= irq_en_r;
          `OFS_FIFO_CTRL: RDATA <= {7'h00, fifo_mode_r};
          `OFS_LINE_CTRL: RDATA <= line_ctrl_r;
          `OFS_MODEM:     RDATA <= modem_control_r;
          `OFS_LSTAT:     RDATA <= line_status_reg;
          `OFS_EVT_STAT:  RDATA <= {5'h00, evt_stat_r};
          `OFS_EVT_MASK:  RDATA <= {5'h00, evt_mask_r};
          default:        RDATA <= 8'h00;
        endcase
      end else begin
        RDATA <= 8'h00;
      end
    end
  end

  // transmit queue
  always @(posedge CLK_SYS) begin
    if (txq_push)
      tx_queue_mem[txq_wp_r] <= WDATA;
  end

  always @(posedge CLK_SYS) begin
    if (!RESETN || q_flush) begin
      txq_wp_r  <= 4'h0;
      txq_rp_r  <= 4'h0;
      txq_cnt_r <= 5'h00;
    end else begin
      if (txq_push)
        txq_wp_r <= txq_wp_r + 4'h1;
      if (txq_pop)
        txq_rp_r <= txq_rp_r + 4'h1;
      if (txq_push & ~txq_pop)
        txq_cnt_r <= txq_cnt_r + 5'h01;
      else if (txq_pop & ~txq_push)
        txq_cnt_r <= txq_cnt_r - 5'h01;
    end
  end

  // transmit shifter, lsb first
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      tx_busy_r    <= 1'b0;
      tx_shift_reg <= 11'h7ff;
      tx_bits_r    <= 4'h0;
      tx_cnt_r     <= 16'h0000;
      TXD          <= 1'b1;
    end else begin
      TXD <= tx_busy_r ? tx_shift_reg[0] : 1'b1;
      if (txq_pop) begin
        tx_busy_r    <= 1'b1;
        tx_shift_reg <= par_en ? {1'b1, tx_par, tx_byte, 1'b0}
                               : {2'b11, tx_byte, 1'b0};
        tx_bits_r    <= par_en ? 4'hb : 4'ha;
        tx_cnt_r     <= `BIT_CYCLES - 16'h0001;
      end else if (tx_busy_r) begin
        if (tx_cnt_r != 16'h0000) begin
          tx_cnt_r <= tx_cnt_r - 16'h0001;
        end else if (tx_bits_r == 4'h1) begin
          tx_busy_r <= 1'b0;
        end else begin
          tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
          tx_bits_r    <= tx_bits_r - 4'h1;
          tx_cnt_r     <= `BIT_CYCLES - 16'h0001;
        end
      end
    end
  end

  // receive line filter: second and third stage must agree
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      rx_s3_r  <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s1_r <= RXD;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r)
        rx_lvl_r <= rx_s3_r;
    end
  end

  // receive framing
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_idx_r <= 4'h0;
      rx_sh_r  <= 9'h000;
    end else begin
      if (rx_cnt_r != 16'h0000)
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      case (rx_st_r)
        RX_IDLE: begin
          if (!rx_lvl_r) begin
            rx_st_r  <= RX_START;
            rx_cnt_r <= `HALF_CYCLES - 16'h0001;
          end
        end
        RX_START: begin
          if (rx_cnt_r == 16'h0000) begin
            if (!rx_lvl_r) begin
              rx_st_r  <= RX_DATA;
              rx_cnt_r <= `BIT_CYCLES - 16'h0001;
              rx_idx_r <= 4'h0;
              rx_sh_r  <= 9'h000;
            end else begin
              rx_st_r <= RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (rx_cnt_r == 16'h0000) begin
            rx_sh_r[rx_idx_r] <= rx_lvl_r;
            rx_cnt_r <= `BIT_CYCLES - 16'h0001;
            if (rx_idx_r == (par_en ? 4'h8 : 4'h7))
              rx_st_r <= RX_STOP;
            else
              rx_idx_r <= rx_idx_r + 4'h1;
          end
        end
        RX_STOP: begin
          if (rx_cnt_r == 16'h0000) begin
            if (rx_fe) begin
              // low stop taken as next start, checked once more
              rx_st_r  <= RX_START;
              rx_cnt_r <= `HALF_CYCLES - 16'h0001;
            end else begin
              rx_st_r <= RX_IDLE;
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // receive queue
  always @(posedge CLK_SYS) begin
    if (rxq_push)
      rxq_mem[rxq_wp_r] <= rx_entry;
    else if (rxq_ovw)
      rxq_mem[rxq_rp_r] <= rx_entry;
  end

  always @* begin
    rx_err_cnt_nxt = rx_err_cnt_r;
    if (rxq_push & rx_entry_err)
      rx_err_cnt_nxt = rx_err_cnt_nxt + 5'h01;
    if (rxq_ovw & rx_entry_err)
      rx_err_cnt_nxt = rx_err_cnt_nxt + 5'h01;
    if ((rxq_pop | rxq_ovw) & head_err)
      rx_err_cnt_nxt = rx_err_cnt_nxt - 5'h01;
  end

  always @(posedge CLK_SYS) begin
    if (!RESETN || q_flush) begin
      rxq_wp_r     <= 4'h0;
      rxq_rp_r     <= 4'h0;
      rxq_cnt_r    <= 5'h00;
      rx_err_cnt_r <= 5'h00;
      head_shown_r <= 1'b0;
    end else begin
      rx_err_cnt_r <= rx_err_cnt_nxt;
      if (rxq_push)
        rxq_wp_r <= rxq_wp_r + 4'h1;
      if (rxq_pop)
        rxq_rp_r <= rxq_rp_r + 4'h1;
      if (rxq_push & ~rxq_pop)
        rxq_cnt_r <= rxq_cnt_r + 5'h01;
      else if (rxq_pop & ~rxq_push)
        rxq_cnt_r <= rxq_cnt_r - 5'h01;
      if (rxq_pop | rxq_ovw)
        head_shown_r <= 1'b0;
      else if (show_evt)
        head_shown_r <= 1'b1;
    end
  end

  // aggregated queue error: a fresh error wins over the read clear
  always @* begin
    fifo_err_nxt = fifo_err_r;
    if (rd_lstat && (rx_err_cnt_nxt == 5'h00))
      fifo_err_nxt = 1'b0;
    if (fifo_mode_r & rxq_push & rx_entry_err)
      fifo_err_nxt = 1'b1;
    if (!fifo_mode_r)
      fifo_err_nxt = 1'b0;
  end

  // line status flags; writes at the status offset are ignored
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      overrun_r    <= 1'b0;
      parity_err_r <= 1'b0;
      frame_err_r  <= 1'b0;
      break_r      <= 1'b0;
      fifo_err_r   <= 1'b0;
    end else begin
      fifo_err_r   <= fifo_err_nxt;
      overrun_r    <= rx_overrun | (overrun_r & ~rd_lstat);
      parity_err_r <= (show_evt & rx_head[8]) |
                      (parity_err_r & ~rd_lstat);
      frame_err_r  <= (show_evt & rx_head[9]) |
                      (frame_err_r & ~rd_lstat);
      break_r      <= (show_evt & rx_head[10]) |
                      (break_r & ~rd_lstat);
    end
  end

endmodule

// ### sim/uart_lsl_monitor.sv
// Purpose: port-level checks of the line status logic
// Assumes: single clock, sync active-low reset
// Notes:   shadows of enables and mask are kept from register writes
`timescale 1ns/1ps
`include "uart_lsl_consts.vh"

module uart_lsl_monitor (
  // clock and reset
  input wire       CLK_SYS,
  input wire       RESETN,
  // register port
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  // line and outputs
  input wire       RXD,
  input wire       TXD,
  input wire       TERMINAL_READY_OUT_N,
  input wire       SERIAL_IRQ,
  input wire       IRQ
);
  reg [2:0] ien_r;
  reg [2:0] mask_r;
  reg       fifo_r;
  reg [7:0] tx_hi_r;
  reg [7:0] rx_hi_r;
  wire      st_rd = RD && ADDR == `OFS_LSTAT;

  // saturating counts of idle-high line cycles
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ien_r   <= 3'h0;
      mask_r  <= 3'h0;
      fifo_r  <= 1'b0;
      tx_hi_r <= 8'h00;
      rx_hi_r <= 8'h00;
    end else begin
      if (WR && ADDR == `OFS_IRQ_EN) ien_r <= WDATA[2:0];
      if (WR && ADDR == `OFS_EVT_MASK) mask_r <= WDATA[2:0];
      if (WR && ADDR == `OFS_FIFO_CTRL) fifo_r <= WDATA[0];
      tx_hi_r <= !TXD ? 8'h00 : (tx_hi_r == 8'hff ? 8'hff : tx_hi_r + 8'h01);
      rx_hi_r <= !RXD ? 8'h00 : (rx_hi_r == 8'hff ? 8'hff : rx_hi_r + 8'h01);
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside read answer");
  a_term_ready: assert property (
    (WR && ADDR == `OFS_MODEM) ##1 !(WR && ADDR == `OFS_MODEM)
    |=> TERMINAL_READY_OUT_N == !$past(WDATA[`MC_TERM_READY], 2))
    else $error("terminal ready output does not follow control bit");
  a_fifo_err_zero: assert property (
    $past(!fifo_r && st_rd) |-> !RDATA[`LS_FIFO_ERR])
    else $error("fifo error flag set in 450 mode");
  a_empty_order: assert property (
    $past(st_rd) && RDATA[`LS_TX_EMPTY] |-> RDATA[`LS_HOLD_EMPTY])
    else $error("transmitter empty while holding register full");
  a_hold_irq: assert property (
    $past(st_rd && ien_r[`IE_HOLD_EMPTY]) && RDATA[`LS_HOLD_EMPTY]
    |-> $past(SERIAL_IRQ))
    else $error("holding empty enabled but no serial interrupt");
  a_tx_start: assert property (
    WR && ADDR == `OFS_DATA && tx_hi_r == 8'hff |-> ##3 (!TXD) [*8])
    else $error("idle transmitter did not start frame");
  a_err_clear: assert property (
    (rx_hi_r == 8'hff && st_rd) ##1 !RD ##1 st_rd
    |=> RDATA[4:1] == 4'h0)
    else $error("error flags survive a status read");
  a_irq_masked: assert property (mask_r == 3'h0 |-> !IRQ)
    else $error("event interrupt with all events masked");

  c_tx_start: cover property (WR && ADDR == `OFS_DATA);
  c_irq_rise: cover property ($rose(IRQ));
  c_fifo_err: cover property ($past(st_rd) && RDATA[`LS_FIFO_ERR]);
  c_overrun:  cover property ($past(st_rd) && RDATA[`LS_OVERRUN]);
endmodule

bind uart_line_status_logic uart_lsl_monitor mon (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD),
  .TERMINAL_READY_OUT_N(TERMINAL_READY_OUT_N),
  .SERIAL_IRQ(SERIAL_IRQ), .IRQ(IRQ));

// ### sim/line_peer.sv
// Purpose: remote serial device on the line
// Assumes: 16 clock cycles a bit, idle high
// Notes:   a low stop bit is cut short so the line is high before rearm
`timescale 1ns/1ps

module line_peer (
  // clock
  input wire       clk,
  // line
  output reg       line_rx,
  input wire       line_tx
);
  reg [7:0] got_byte;
  integer   got_cnt;
  integer   j;

  initial begin
    line_rx = 1'b1;
    got_cnt = 0;
    got_byte = 8'h00;
    forever begin
      wait (line_tx === 1'b1);
      wait (line_tx === 1'b0);
      repeat (8) @(posedge clk);
      for (j = 0; j < 8; j = j + 1) begin
        repeat (16) @(posedge clk);
        got_byte[j] = line_tx;
      end
      repeat (16) @(posedge clk);
      got_cnt = got_cnt + 1;
    end
  end

  // start, data lsb first, optional parity, stop
  task send(input [7:0] d, input pe, input p, input s);
    integer i;
    reg [10:0] f;
    begin
      f = pe ? {s, p, d, 1'b0} : {1'b1, s, d, 1'b0};
      @(posedge clk);
      for (i = 0; i < 11; i = i + 1) begin
        line_rx <= f[i];
        repeat ((i == (pe ? 10 : 9) && !s) ? 10 : 16) @(posedge clk);
      end
      line_rx <= 1'b1;
      repeat (32) @(posedge clk);
    end
  endtask
endmodule

// ### sim/tb_top.sv
// Purpose: self-checking bench of the line status logic
// Assumes: peer model drives the receive line
// Notes:   one task a scenario, register port driven on rising edges
`timescale 1ns/1ps
`include "uart_lsl_consts.vh"
`define CHK(a, b) begin cmp_count = cmp_count + 1; if ((a) !== (b)) begin \
  n_errors = n_errors + 1; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end

module tb_top;
  reg        CLK_SYS = 1'b0;
  reg        RESETN  = 1'b0;
  reg  [3:0] ADDR    = 4'h0;
  reg  [7:0] WDATA   = 8'h00;
  reg        WR      = 1'b0;
  reg        RD      = 1'b0;
  wire [7:0] RDATA;
  wire       RXD;
  wire       TXD;
  wire       TERMINAL_READY_OUT_N;
  wire       SERIAL_IRQ;
  wire       IRQ;
  integer    n_errors  = 0;
  integer    cmp_count = 0;
  reg  [7:0] v;
  integer    i;

  always #2.5 CLK_SYS = ~CLK_SYS;

  uart_line_status_logic DUT (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD),
    .TERMINAL_READY_OUT_N(TERMINAL_READY_OUT_N),
    .SERIAL_IRQ(SERIAL_IRQ), .IRQ(IRQ));
  line_peer peer (.clk(CLK_SYS), .line_rx(RXD), .line_tx(TXD));

  task tick;
    begin @(posedge CLK_SYS); #1; end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge CLK_SYS); ADDR <= a; WDATA <= d; WR <= 1'b1;
      @(posedge CLK_SYS); WR <= 1'b0; #1;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge CLK_SYS); ADDR <= a; RD <= 1'b1;
      @(posedge CLK_SYS); RD <= 1'b0; #1 d = RDATA;
    end
  endtask

  task t_regs;
    begin
      rd(`OFS_LSTAT, v); `CHK(v, 8'h60)
      wr(`OFS_LSTAT, 8'hff); rd(`OFS_LSTAT, v); `CHK(v, 8'h60)
      rd(4'hf, v); `CHK(v, 8'h00)
      wr(`OFS_MODEM, 8'h01); tick; `CHK(TERMINAL_READY_OUT_N, 1'b0)
      wr(`OFS_MODEM, 8'h00); tick; `CHK(TERMINAL_READY_OUT_N, 1'b1)
      $display("test regs ends");
    end
  endtask

  task t_rx_450;
    begin
      peer.send(8'h3c, 1'b0, 1'b0, 1'b1);
      rd(`OFS_LSTAT, v); `CHK(v, 8'h61)
      peer.send(8'h55, 1'b0, 1'b0, 1'b1);
      rd(`OFS_LSTAT, v); `CHK(v, 8'h63)
      repeat (260) tick;
      rd(`OFS_LSTAT, v); `CHK(v, 8'h61)
      rd(`OFS_LSTAT, v); `CHK(v, 8'h61)
      rd(`OFS_DATA, v); `CHK(v, 8'h55)
      rd(`OFS_LSTAT, v); `CHK(v, 8'h60)
      $display("test rx 450 ends");
    end
  endtask

  task t_tx;
    integer n;
    begin
      wr(`OFS_EVT_MASK, 8'h04); wr(`OFS_IRQ_EN, 8'h02);
      `CHK(SERIAL_IRQ, 1'b1)
      n = peer.got_cnt;
      wr(`OFS_DATA, 8'ha5);
      rd(`OFS_LSTAT, v); `CHK(v, 8'h20)
      for (i = 0; i < 400 && peer.got_cnt == n; i = i + 1) tick;
      `CHK(peer.got_byte, 8'ha5)
      `CHK(IRQ, 1'b1)
      wr(`OFS_EVT_STAT, 8'h04); `CHK(IRQ, 1'b0)
      repeat (20) tick;
      rd(`OFS_LSTAT, v); `CHK(v, 8'h60)
      wr(`OFS_IRQ_EN, 8'h00); wr(`OFS_EVT_MASK, 8'h00);
      $display("test tx ends");
    end
  endtask

  // parity error, framing error, break, then a clean byte
  task t_rx_err;
    reg [31:0] d4;
    reg [31:0] st4;
    reg [3:0]  p4;
    reg [3:0]  s4;
    begin
      d4 = 32'h07000201; st4 = 32'he1f9e9e5; p4 = 4'b1010; s4 = 4'b1001;
      wr(`OFS_FIFO_CTRL, 8'h01); wr(`OFS_LINE_CTRL, 8'h18);
      for (i = 0; i < 4; i = i + 1)
        peer.send(d4[i*8 +: 8], 1'b1, p4[i], s4[i]);
      for (i = 0; i < 4; i = i + 1) begin
        rd(`OFS_LSTAT, v); `CHK(v, st4[i*8 +: 8])
        rd(`OFS_DATA, v); `CHK(v, d4[i*8 +: 8])
        tick;
      end
      rd(`OFS_LSTAT, v); `CHK(v, 8'h60)
      $display("test rx errors ends");
    end
  endtask

  task t_overrun;
    begin
      wr(`OFS_LINE_CTRL, 8'h00);
      for (i = 0; i < 17; i = i + 1) peer.send(i[7:0], 1'b0, 1'b0, 1'b1);
      rd(`OFS_LSTAT, v); `CHK(v, 8'h63)
      for (i = 0; i < 16; i = i + 1) begin
        rd(`OFS_DATA, v); `CHK(v, i[7:0])
      end
      rd(`OFS_LSTAT, v); `CHK(v, 8'h60)
      $display("test overrun ends");
    end
  endtask

  // odd parity receive, then two queued bytes in fifo mode
  task t_odd_fifo;
    integer n;
    begin
      wr(`OFS_LINE_CTRL, 8'h08); wr(`OFS_IRQ_EN, 8'h04);
      peer.send(8'h03, 1'b1, 1'b0, 1'b1);
      `CHK(SERIAL_IRQ, 1'b1)
      rd(`OFS_LSTAT, v); `CHK(v, 8'he5)
      `CHK(SERIAL_IRQ, 1'b0)
      rd(`OFS_DATA, v); `CHK(v, 8'h03)
      rd(`OFS_LSTAT, v); `CHK(v, 8'he0)
      peer.send(8'h01, 1'b1, 1'b0, 1'b1);
      rd(`OFS_LSTAT, v); `CHK(v, 8'h61)
      rd(`OFS_DATA, v); `CHK(v, 8'h01)
      n = peer.got_cnt;
      wr(`OFS_DATA, 8'h5a); wr(`OFS_DATA, 8'hc3);
      rd(`OFS_LSTAT, v); `CHK(v, 8'h00)
      for (i = 0; i < 600 && peer.got_cnt < n + 2; i = i + 1) tick;
      `CHK(peer.got_byte, 8'hc3)
      repeat (40) tick;
      rd(`OFS_LSTAT, v); `CHK(v, 8'h60)
      wr(`OFS_IRQ_EN, 8'h00);
      $display("test odd parity and fifo tx ends");
    end
  endtask

  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  initial begin
    repeat (10) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    t_regs;
    t_rx_450;
    t_tx;
    t_rx_err;
    t_overrun;
    t_odd_fifo;
    final_report;
  end

  initial begin
    repeat (40000) @(posedge CLK_SYS);
    n_errors = n_errors + 1;
    final_report;
  end
endmodule
